// ---- common/pfp_pkg.sv ----
package pfp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_BUS_OV1 = 5'h01;
  localparam logic [4:0] ADDR_BUS_RESUME = 5'h02;
  localparam logic [4:0] ADDR_OV2_BLANK = 5'h03;
  localparam logic [4:0] ADDR_OV1_BLANK = 5'h04;
  localparam logic [4:0] ADDR_IN_UV = 5'h05;
  localparam logic [4:0] ADDR_IN_OV = 5'h06;
  localparam logic [4:0] ADDR_START_MIN = 5'h07;
  localparam logic [4:0] ADDR_START_MAX = 5'h08;
  localparam logic [4:0] ADDR_VIN_BLANK = 5'h09;
  localparam logic [4:0] ADDR_RMS_RESET = 5'h0A;
  localparam logic [4:0] ADDR_CCM_BLANK = 5'h0B;
  localparam logic [4:0] ADDR_SS_LIMIT = 5'h0C;
  localparam logic [4:0] ADDR_PDC = 5'h0D;
  localparam logic [4:0] ADDR_CS_OFFSET = 5'h0E;
  localparam logic [4:0] ADDR_RCS_INV = 5'h0F;
  localparam logic [4:0] ADDR_VOUT_GAIN = 5'h10;
  localparam logic [4:0] ADDR_VOUT_OFFSET = 5'h11;
  localparam logic [4:0] ADDR_IOUT_GAIN = 5'h12;
  localparam logic [4:0] ADDR_BUSFB_GAIN = 5'h13;
  localparam logic [4:0] ADDR_BUSFB_OFFSET = 5'h14;
  localparam logic [4:0] ADDR_PLAUS_TOL = 5'h15;
  localparam logic [4:0] ADDR_VOUT_OV = 5'h16;
  localparam logic [4:0] ADDR_VOUT_UV = 5'h17;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [4:0] ADDR_EVENTS = 5'h19;
  localparam logic [4:0] ADDR_IPK = 5'h1A;
  localparam logic [4:0] ADDR_VOUT = 5'h1B;
  localparam logic [4:0] ADDR_IOUT = 5'h1C;
  localparam logic [4:0] ADDR_BUSFB = 5'h1D;

  // ----------------------------------------------------------------
  // Control bits, event bits, constants
  // ----------------------------------------------------------------
  localparam int CTRL_IN_OV_EN = 0;
  localparam int CTRL_SS_START = 1;
  localparam int CTRL_SS_DONE = 2;
  localparam int CTRL_STAGE2_ON = 3;
  localparam int CTRL_DCM = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int NEV = 10;
  localparam int EV_BUS_OV1 = 0;
  localparam int EV_BUS_OV2 = 1;
  localparam int EV_IN_UV = 2;
  localparam int EV_IN_OV = 3;
  localparam int EV_OC2 = 4;
  localparam int EV_CCM = 5;
  localparam int EV_SS_FAIL = 6;
  localparam int EV_VOUT_OV = 7;
  localparam int EV_VOUT_UV = 8;
  localparam int EV_PLAUS = 9;
  // 2.8 V at the bus sense pin on a 12-bit, 3.3 V full-scale code
  localparam logic [11:0] BUS_OV2_CODE = 12'hD93;
  localparam logic [15:0] ONES16 = 16'hFFFF;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam int FRAC = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] bus;
    logic [11:0] vin_rms;
    logic [11:0] cs_flyback;
    logic [11:0] zero_crossing_input;
    logic [11:0] zcd_clamp;
  } pfp_adc_t;

  typedef struct packed {
    logic boost_cs_high;
    logic boost_maxper_on;
    logic zcd_osc_seen;
    logic fb_cs_sample;
    logic fb_demag_end;
    logic fb_on_end;
    logic first_valley;
  } pfp_strobe_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pfp_bus_t;

endpackage : pfp_pkg

// ---- rtl/pfp_top.sv ----
// Function
// - Bus above limit one longer than blanking stops boost gate
// - After that stop, boost resumes only below the resume level
// - Fixed hardware bus trip at 2.8 V code with programmable blanking
// - RMS input below undervoltage limit beyond blanking triggers protection
// - RMS input above overvoltage limit beyond blanking triggers protection
// - Startup min/max thresholds until the startup rms reset timer expires
// - Input overvoltage protection disabled after reset
// - Boost current sense pin held high triggers second-level overcurrent
// - Max-period turn-on without zero-crossing oscillation marks continuous conduction
// - Continuous conduction trips only when persisting beyond its blanking
// - Soft start time reaching its limit before done triggers failure
// - Discontinuous mode delays the next flyback cycle past first valley
// - Flyback sense voltage sampled a fixed time before gate turn-off
// - Peak current = v/R * (ton + comp) / (ton - offset)
// - Output voltage from demag-end sample, gain and offset
// - Derived output voltage feeds output over/undervoltage checks
// - Average output current from peak current, demag time and period
// - Redundant bus voltage from clamp current at end of on-time
// - Redundant bus voltage checked against sensed bus voltage
// - Input under/overvoltage protection aborts the boost soft start
//
// The plain strobed port and the placing of the registers were decided locally.
module pfp_top
  import pfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pfp_bus_t bus_in,
  input wire pfp_adc_t adc,
  input wire pfp_strobe_t strobe_pin,
  input wire logic [NEV-1:0] event_consume,
  output logic [31:0] rdata,
  output logic boost_gate_en,
  output logic fb_valley_delay,
  output logic soft_start_active,
  output logic [NEV-1:0] event_flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_RUN = 2'b01,
    SS_DONE = 2'b10,
    SS_ABORT = 2'b11
  } pfp_ss_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [11:0] bus_ov1;
    logic [11:0] bus_resume;
    logic [15:0] ov2_blank;
    logic [15:0] ov1_blank;
    logic [11:0] in_uv;
    logic [11:0] in_ov;
    logic [11:0] start_min;
    logic [11:0] start_max;
    logic [15:0] vin_blank;
    logic [15:0] rms_reset;
    logic [15:0] ccm_blank;
    logic [15:0] ss_limit;
    logic [15:0] pdc;
    logic [15:0] cs_offset;
    logic [15:0] rcs_inv;
    logic [15:0] vout_gain;
    logic [15:0] vout_offset;
    logic [15:0] iout_gain;
    logic [15:0] busfb_gain;
    logic [15:0] busfb_offset;
    logic [11:0] plaus_tol;
    logic [15:0] vout_ov;
    logic [15:0] vout_uv;
    logic [15:0] c_ov1;
    logic [15:0] c_ov2;
    logic [15:0] c_uv;
    logic [15:0] c_iov;
    logic [15:0] c_rms;
    logic [15:0] c_ccm;
    logic [15:0] c_ss;
    logic [15:0] c_ton;
    logic [15:0] c_tsw;
    logic [15:0] c_demag;
    logic [15:0] ton;
    logic [15:0] tsw;
    logic [15:0] tdemag;
    logic [15:0] vsh;
    logic [15:0] ipk;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] busfb;
    logic ov1_tripped;
    logic startup_done;
    logic osc_seen;
    pfp_ss_t ss;
    logic ss_active;
    logic [NEV-1:0] ev;
    pfp_strobe_t s1;
    pfp_strobe_t s2;
    pfp_strobe_t s3;
    logic [31:0] rdata;
    logic gate_en;
    logic valley_delay;
  } pfp_state_t;

  pfp_state_t st_reg;
  pfp_state_t st_next;

  // Saturating blanking counter: counts while the condition holds, clears when it drops
  function automatic logic [15:0] blank_cnt(input logic cond, input logic [15:0] c);
    blank_cnt = !cond ? 16'h0000 : (c == ONES16 ? c : c + 16'h0001);
  endfunction : blank_cnt

  function automatic logic [15:0] mulq(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = a * b;
    mulq = p[FRAC+15:FRAC];
  endfunction : mulq

  function automatic logic [15:0] sat_inc(input logic [15:0] c);
    sat_inc = (c == ONES16) ? c : c + 16'h0001;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] lo_th;
    logic [11:0] hi_th;
    logic uv_cond;
    logic ov_cond;
    logic [15:0] den;
    logic [31:0] num;
    logic [31:0] q;
    logic [31:0] iprod;
    logic [15:0] diff;
    logic [NEV-1:0] set_ev;
    lo_th = 12'h000;
    hi_th = 12'h000;
    uv_cond = 1'b0;
    ov_cond = 1'b0;
    den = 16'h0000;
    num = 32'h0000_0000;
    q = 32'h0000_0000;
    iprod = 32'h0000_0000;
    diff = 16'h0000;
    set_ev = '0;
    st_next = st_reg;
    st_next.s1 = strobe_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        ADDR_CTRL: st_next.ctrl = bus_in.wdata[7:0];
        ADDR_BUS_OV1: st_next.bus_ov1 = bus_in.wdata[11:0];
        ADDR_BUS_RESUME: st_next.bus_resume = bus_in.wdata[11:0];
        ADDR_OV2_BLANK: st_next.ov2_blank = bus_in.wdata[15:0];
        ADDR_OV1_BLANK: st_next.ov1_blank = bus_in.wdata[15:0];
        ADDR_IN_UV: st_next.in_uv = bus_in.wdata[11:0];
        ADDR_IN_OV: st_next.in_ov = bus_in.wdata[11:0];
        ADDR_START_MIN: st_next.start_min = bus_in.wdata[11:0];
        ADDR_START_MAX: st_next.start_max = bus_in.wdata[11:0];
        ADDR_VIN_BLANK: st_next.vin_blank = bus_in.wdata[15:0];
        ADDR_RMS_RESET: st_next.rms_reset = bus_in.wdata[15:0];
        ADDR_CCM_BLANK: st_next.ccm_blank = bus_in.wdata[15:0];
        ADDR_SS_LIMIT: st_next.ss_limit = bus_in.wdata[15:0];
        ADDR_PDC: st_next.pdc = bus_in.wdata[15:0];
        ADDR_CS_OFFSET: st_next.cs_offset = bus_in.wdata[15:0];
        ADDR_RCS_INV: st_next.rcs_inv = bus_in.wdata[15:0];
        ADDR_VOUT_GAIN: st_next.vout_gain = bus_in.wdata[15:0];
        ADDR_VOUT_OFFSET: st_next.vout_offset = bus_in.wdata[15:0];
        ADDR_IOUT_GAIN: st_next.iout_gain = bus_in.wdata[15:0];
        ADDR_BUSFB_GAIN: st_next.busfb_gain = bus_in.wdata[15:0];
        ADDR_BUSFB_OFFSET: st_next.busfb_offset = bus_in.wdata[15:0];
        ADDR_PLAUS_TOL: st_next.plaus_tol = bus_in.wdata[11:0];
        ADDR_VOUT_OV: st_next.vout_ov = bus_in.wdata[15:0];
        ADDR_VOUT_UV: st_next.vout_uv = bus_in.wdata[15:0];
        default: ;
      endcase
    end

    // --------------------------------------------------------------
    // Bus overvoltage
    // --------------------------------------------------------------
    st_next.c_ov1 = blank_cnt(adc.bus > st_reg.bus_ov1, st_reg.c_ov1);
    if (st_reg.c_ov1 > st_reg.ov1_blank) begin
      st_next.ov1_tripped = 1'b1;
      set_ev[EV_BUS_OV1] = 1'b1;
    end else if (st_reg.ov1_tripped && adc.bus < st_reg.bus_resume) begin
      st_next.ov1_tripped = 1'b0;
    end
    st_next.c_ov2 = blank_cnt(adc.bus > BUS_OV2_CODE, st_reg.c_ov2);
    set_ev[EV_BUS_OV2] = st_reg.c_ov2 > st_reg.ov2_blank;
    st_next.gate_en = !st_next.ov1_tripped && !set_ev[EV_BUS_OV2];

    // --------------------------------------------------------------
    // Input voltage, startup thresholds
    // --------------------------------------------------------------
    if (!st_reg.ctrl[CTRL_STAGE2_ON]) begin
      st_next.c_rms = 16'h0000;
    end else if (!st_reg.startup_done) begin
      st_next.c_rms = sat_inc(st_reg.c_rms);
      st_next.startup_done = st_reg.c_rms >= st_reg.rms_reset;
    end
    lo_th = st_reg.startup_done ? st_reg.in_uv : st_reg.start_min;
    hi_th = st_reg.startup_done ? st_reg.in_ov : st_reg.start_max;
    uv_cond = adc.vin_rms < lo_th;
    ov_cond = adc.vin_rms > hi_th && st_reg.ctrl[CTRL_IN_OV_EN];
    st_next.c_uv = blank_cnt(uv_cond, st_reg.c_uv);
    st_next.c_iov = blank_cnt(ov_cond, st_reg.c_iov);
    set_ev[EV_IN_UV] = st_reg.c_uv > st_reg.vin_blank;
    set_ev[EV_IN_OV] = st_reg.c_iov > st_reg.vin_blank;

    // --------------------------------------------------------------
    // Boost current sense and continuous conduction
    // --------------------------------------------------------------
    set_ev[EV_OC2] = st_reg.s2.boost_cs_high;
    st_next.osc_seen = st_reg.osc_seen || st_reg.s2.zcd_osc_seen;
    if (st_reg.s2.boost_maxper_on && !st_reg.s3.boost_maxper_on) begin
      st_next.osc_seen = 1'b0;
      if (!st_reg.osc_seen && !st_reg.s2.zcd_osc_seen) begin
        st_next.c_ccm = sat_inc(st_reg.c_ccm);
      end else begin
        st_next.c_ccm = 16'h0000;
      end
    end
    // Only a run of turn-ons without oscillation trips, so startup episodes pass
    set_ev[EV_CCM] = st_reg.c_ccm > st_reg.ccm_blank;

    // --------------------------------------------------------------
    // Soft start
    // --------------------------------------------------------------
    unique case (st_reg.ss)
      SS_IDLE: begin
        st_next.c_ss = 16'h0000;
        if (st_reg.ctrl[CTRL_SS_START]) begin
          st_next.ss = SS_RUN;
        end
      end
      SS_RUN: begin
        st_next.c_ss = sat_inc(st_reg.c_ss);
        if (set_ev[EV_IN_UV] || set_ev[EV_IN_OV]) begin
          st_next.ss = SS_ABORT;
        end else if (st_reg.ctrl[CTRL_SS_DONE]) begin
          st_next.ss = SS_DONE;
        end else if (st_reg.c_ss >= st_reg.ss_limit) begin
          set_ev[EV_SS_FAIL] = 1'b1;
          st_next.ss = SS_ABORT;
        end
      end
      SS_DONE: begin
        if (!st_reg.ctrl[CTRL_SS_START]) begin
          st_next.ss = SS_IDLE;
        end
      end
      SS_ABORT: begin
        if (!st_reg.ctrl[CTRL_SS_START]) begin
          st_next.ss = SS_IDLE;
        end
      end
    endcase
    st_next.ss_active = st_next.ss == SS_RUN;

    // --------------------------------------------------------------
    // Flyback timing and sampling
    // --------------------------------------------------------------
    st_next.c_ton = sat_inc(st_reg.c_ton);
    st_next.c_tsw = sat_inc(st_reg.c_tsw);
    st_next.c_demag = sat_inc(st_reg.c_demag);
    if (st_reg.s2.fb_cs_sample && !st_reg.s3.fb_cs_sample) begin
      st_next.vsh = {4'h0, adc.cs_flyback};
    end
    if (st_reg.s2.fb_on_end && !st_reg.s3.fb_on_end) begin
      st_next.ton = st_reg.c_ton;
      st_next.tsw = st_reg.c_tsw;
      st_next.c_tsw = 16'h0000;
      st_next.c_demag = 16'h0000;
      den = st_reg.c_ton - st_reg.cs_offset;
      num = {16'h0000, mulq(st_reg.vsh, st_reg.rcs_inv)} * {16'h0000, st_reg.c_ton + st_reg.pdc};
      q = (den == 16'h0000) ? ZERO32 : num / {16'h0000, den};
      st_next.ipk = q[31:16] != 16'h0000 ? ONES16 : q[15:0];
      // Clamp current measured at the end of on-time
      st_next.busfb = mulq({4'h0, adc.zcd_clamp}, st_reg.busfb_gain) + st_reg.busfb_offset;
    end
    if (st_reg.s2.fb_demag_end && !st_reg.s3.fb_demag_end) begin
      st_next.tdemag = st_reg.c_demag;
      st_next.c_ton = 16'h0000;
      st_next.vout = mulq({4'h0, adc.zero_crossing_input}, st_reg.vout_gain) + st_reg.vout_offset;
      // Divide by period once per cycle, not every clock
      iprod = {16'h0000, mulq(st_reg.ipk, st_reg.iout_gain)} * {16'h0000, st_reg.c_demag};
      q = (st_reg.tsw == 16'h0000) ? ZERO32 : iprod / {16'h0000, st_reg.tsw};
      st_next.iout = q[31:16] != 16'h0000 ? ONES16 : q[15:0];
    end
    set_ev[EV_VOUT_OV] = st_reg.vout > st_reg.vout_ov;
    set_ev[EV_VOUT_UV] = st_reg.ss == SS_DONE && st_reg.vout < st_reg.vout_uv;
    diff = st_reg.busfb > {4'h0, adc.bus} ? st_reg.busfb - {4'h0, adc.bus}
                                          : {4'h0, adc.bus} - st_reg.busfb;
    set_ev[EV_PLAUS] = st_reg.tsw != 16'h0000 && diff > {4'h0, st_reg.plaus_tol};
    st_next.valley_delay = st_reg.ctrl[CTRL_DCM] && st_reg.s2.first_valley;

    // Set wins over a consume in the same cycle
    st_next.ev = (st_reg.ev & ~event_consume) | set_ev;

    // --------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------
    st_next.rdata = ZERO32;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        ADDR_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
        ADDR_BUS_OV1: st_next.rdata = {20'h0, st_reg.bus_ov1};
        ADDR_BUS_RESUME: st_next.rdata = {20'h0, st_reg.bus_resume};
        ADDR_OV2_BLANK: st_next.rdata = {16'h0, st_reg.ov2_blank};
        ADDR_OV1_BLANK: st_next.rdata = {16'h0, st_reg.ov1_blank};
        ADDR_IN_UV: st_next.rdata = {20'h0, st_reg.in_uv};
        ADDR_IN_OV: st_next.rdata = {20'h0, st_reg.in_ov};
        ADDR_START_MIN: st_next.rdata = {20'h0, st_reg.start_min};
        ADDR_START_MAX: st_next.rdata = {20'h0, st_reg.start_max};
        ADDR_VIN_BLANK: st_next.rdata = {16'h0, st_reg.vin_blank};
        ADDR_RMS_RESET: st_next.rdata = {16'h0, st_reg.rms_reset};
        ADDR_CCM_BLANK: st_next.rdata = {16'h0, st_reg.ccm_blank};
        ADDR_SS_LIMIT: st_next.rdata = {16'h0, st_reg.ss_limit};
        ADDR_PDC: st_next.rdata = {16'h0, st_reg.pdc};
        ADDR_CS_OFFSET: st_next.rdata = {16'h0, st_reg.cs_offset};
        ADDR_RCS_INV: st_next.rdata = {16'h0, st_reg.rcs_inv};
        ADDR_VOUT_GAIN: st_next.rdata = {16'h0, st_reg.vout_gain};
        ADDR_VOUT_OFFSET: st_next.rdata = {16'h0, st_reg.vout_offset};
        ADDR_IOUT_GAIN: st_next.rdata = {16'h0, st_reg.iout_gain};
        ADDR_BUSFB_GAIN: st_next.rdata = {16'h0, st_reg.busfb_gain};
        ADDR_BUSFB_OFFSET: st_next.rdata = {16'h0, st_reg.busfb_offset};
        ADDR_PLAUS_TOL: st_next.rdata = {20'h0, st_reg.plaus_tol};
        ADDR_VOUT_OV: st_next.rdata = {16'h0, st_reg.vout_ov};
        ADDR_VOUT_UV: st_next.rdata = {16'h0, st_reg.vout_uv};
        ADDR_STATUS: st_next.rdata = {27'h0, st_reg.startup_done, st_reg.ss,
                                      st_reg.gate_en, st_reg.ov1_tripped};
        ADDR_EVENTS: st_next.rdata = {22'h0, st_reg.ev};
        ADDR_IPK: st_next.rdata = {16'h0, st_reg.ipk};
        ADDR_VOUT: st_next.rdata = {16'h0, st_reg.vout};
        ADDR_IOUT: st_next.rdata = {16'h0, st_reg.iout};
        ADDR_BUSFB: st_next.rdata = {16'h0, st_reg.busfb};
        default: st_next.rdata = ZERO32;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.ss <= SS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign boost_gate_en = st_reg.gate_en;
  assign fb_valley_delay = st_reg.valley_delay;
  assign soft_start_active = st_reg.ss_active;
  assign event_flags = st_reg.ev;

endmodule : pfp_top

// ---- test/pfp_conv_model.sv ----
module pfp_conv_model
  import pfp_pkg::*;
(
  input wire logic clk,
  input wire pfp_adc_t adc_set,
  input wire logic cs_open,
  input wire logic no_osc,
  output pfp_adc_t adc,
  output pfp_strobe_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ph_reg = 4'h0;
  initial begin
    adc = '0;
    pins = '0;
  end
  // ------
  // Fixed 16-cycle converter rhythm
  // ------
  always @(posedge clk) begin
    ph_reg <= ph_reg + 4'h1;
    adc <= adc_set;
    pins.boost_cs_high <= cs_open; // Missing resistor lets the pin float high
    pins.zcd_osc_seen <= (ph_reg == 4'h4) && !no_osc; // No ringing while no_osc models continuous conduction
    pins.boost_maxper_on <= (ph_reg == 4'h9);
    pins.fb_cs_sample <= (ph_reg == 4'h2); // Sample lands before turn-off
    pins.fb_on_end <= (ph_reg == 4'h3);
    pins.fb_demag_end <= (ph_reg == 4'hA);
    pins.first_valley <= (ph_reg == 4'hC);
  end
endmodule : pfp_conv_model

// ---- test/pfp_top_props.sv ----
module pfp_top_props
  import pfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire pfp_bus_t bus_in,
  input wire pfp_adc_t adc,
  input wire pfp_strobe_t strobe_pin,
  input wire logic [NEV-1:0] event_consume,
  input wire logic [31:0] rdata,
  input wire logic boost_gate_en,
  input wire logic fb_valley_delay,
  input wire logic soft_start_active,
  input wire logic [NEV-1:0] event_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Shadow of the settings the properties depend on
  // ------
  logic ov_en_reg;
  logic dcm_reg;
  logic [11:0] resume_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ov_en_reg <= 1'b0;
      dcm_reg <= 1'b0;
      resume_reg <= 12'h000;
    end else if (bus_in.wr) begin
      if (bus_in.addr == ADDR_CTRL) begin
        ov_en_reg <= bus_in.wdata[CTRL_IN_OV_EN];
        dcm_reg <= bus_in.wdata[CTRL_DCM];
      end
      if (bus_in.addr == ADDR_BUS_RESUME) begin
        resume_reg <= bus_in.wdata[11:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_flags_sticky: assert property (
    ($past(event_flags) & ~$past(event_consume) & ~event_flags) == '0)
    else $error("event flag dropped without consume");
  a_ov1_gate: assert property (
    $rose(event_flags[EV_BUS_OV1]) |-> ##[0:2] !boost_gate_en)
    else $error("boost gate still on after bus overvoltage");
  a_resume_level: assert property (
    $rose(boost_gate_en) && $past(rst_n, 4) |-> $past(adc.bus) < resume_reg)
    else $error("boost gate resumed above resume level");
  a_ov2_level: assert property (
    $rose(event_flags[EV_BUS_OV2]) |-> $past(adc.bus, 2) > BUS_OV2_CODE)
    else $error("hardware bus trip below fixed level");
  a_in_ov_off: assert property (
    !ov_en_reg |-> !$rose(event_flags[EV_IN_OV]))
    else $error("input overvoltage fired while disabled");
  a_oc2_open: assert property (
    strobe_pin.boost_cs_high [*8] |-> ##[0:40] event_flags[EV_OC2])
    else $error("open sense resistor not flagged");
  a_abort_soft: assert property (
    $rose(event_flags[EV_IN_UV]) || $rose(event_flags[EV_IN_OV]) |-> ##[0:3] !soft_start_active)
    else $error("soft start kept running after input fault");
  a_ss_fail_run: assert property (
    $rose(event_flags[EV_SS_FAIL]) |-> $past(soft_start_active, 2))
    else $error("soft start failure without running soft start");
  a_valley_idle: assert property (
    !dcm_reg [*4] |-> !fb_valley_delay)
    else $error("valley delay outside discontinuous mode");
endmodule : pfp_top_props

bind pfp_top pfp_top_props u_pfp_top_props (.clk(clk), .rst_n(rst_n), .bus_in(bus_in),
  .adc(adc), .strobe_pin(strobe_pin), .event_consume(event_consume), .rdata(rdata),
  .boost_gate_en(boost_gate_en), .fb_valley_delay(fb_valley_delay),
  .soft_start_active(soft_start_active), .event_flags(event_flags));

// ---- test/pfp_top_tb.sv ----
module pfp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pfp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pfp_bus_t bus_in = '0;
  pfp_adc_t adc_set = '0;
  logic cs_open = 1'b0;
  logic no_osc = 1'b0;
  logic [NEV-1:0] event_consume = '0;
  pfp_adc_t adc;
  pfp_strobe_t strobe_pin;
  logic [31:0] rdata;
  logic boost_gate_en;
  logic fb_valley_delay;
  logic soft_start_active;
  logic [NEV-1:0] event_flags;
  int miscompares = 0;
  int checks_done = 0;
  logic [11:0] v;
  int hits = 0;
  always #25 clk = ~clk;
  pfp_conv_model u_pfp_conv_model (.clk(clk), .adc_set(adc_set), .cs_open(cs_open),
    .no_osc(no_osc), .adc(adc), .pins(strobe_pin));
  pfp_top u_pfp_top (.clk(clk), .rst_n(rst_n), .bus_in(bus_in), .adc(adc),
    .strobe_pin(strobe_pin), .event_consume(event_consume), .rdata(rdata),
    .boost_gate_en(boost_gate_en), .fb_valley_delay(fb_valley_delay),
    .soft_start_active(soft_start_active), .event_flags(event_flags));
  // ------
  // Helpers
  // ------
  function automatic logic over(input logic [11:0] x, input logic [11:0] lim);
    return x > lim;
  endfunction : over
  // Partner rhythm counts 8 on-cycles, 6 demag cycles and a 15-cycle period
  function automatic int ipk_exp(input int v, input int r, input int p, input int o);
    return ((v * r) >> FRAC) * (8 + p) / (8 - o);
  endfunction : ipk_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_in <= '0;
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_in <= '{addr: a, wdata: ZERO32, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_in <= '0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd_chk
  task automatic consume(input logic [NEV-1:0] m);
    @(posedge clk);
    event_consume <= m;
    @(posedge clk);
    event_consume <= '0;
    cyc(1);
  endtask : consume
  task automatic tally_and_finish();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Far longer than the sequence below needs
  initial begin
    #(20000 * 50);
    miscompares++;
    tally_and_finish();
  end
  // ------
  // Scenarios
  // ------
  initial begin
    void'($urandom(20));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h0000_0000);
    rd_chk(ADDR_EVENTS, 32'h0000_0000);
    wr(ADDR_BUS_OV1, 32'h0000_0800);
    wr(ADDR_OV1_BLANK, 32'h0000_0004);
    wr(ADDR_BUS_RESUME, 32'h0000_0700);
    wr(ADDR_OV2_BLANK, 32'h0000_0004);
    repeat (6) begin
      v = 12'($urandom_range(12'hA00, 12'h600));
      @(posedge clk);
      adc_set.bus <= v;
      cyc(14);
      chk(event_flags[EV_BUS_OV1], over(v, 12'h800));
      @(posedge clk);
      adc_set.bus <= 12'h780;
      cyc(14);
      chk(boost_gate_en, !over(v, 12'h800));
      @(posedge clk);
      adc_set.bus <= 12'h600;
      cyc(8);
      chk(boost_gate_en, 1'b1);
      consume(NEV'(1) << EV_BUS_OV1);
      chk(event_flags[EV_BUS_OV1], 1'b0);
    end
    // Exactly at the fixed code must not trip; one code above must
    @(posedge clk);
    adc_set.bus <= BUS_OV2_CODE;
    cyc(14);
    chk(event_flags[EV_BUS_OV2], 1'b0);
    @(posedge clk);
    adc_set.bus <= BUS_OV2_CODE + 12'h001;
    cyc(14);
    chk(event_flags[EV_BUS_OV2], 1'b1);
    @(posedge clk);
    adc_set.bus <= 12'h600;
    adc_set.vin_rms <= 12'h180;
    cyc(8);
    consume('1);
    wr(ADDR_IN_UV, 32'h0000_0200);
    wr(ADDR_IN_OV, 32'h0000_0900);
    wr(ADDR_START_MIN, 32'h0000_0100);
    wr(ADDR_START_MAX, 32'h0000_0A00);
    wr(ADDR_VIN_BLANK, 32'h0000_0004);
    wr(ADDR_RMS_RESET, 32'h0000_0008);
    wr(ADDR_SS_LIMIT, 32'h0000_0400);
    wr(ADDR_CTRL, 32'h0000_0002);
    cyc(20);
    chk(event_flags[EV_IN_UV], 1'b0);
    chk(soft_start_active, 1'b1);
    wr(ADDR_CTRL, 32'h0000_000A);
    cyc(30);
    chk(event_flags[EV_IN_UV], 1'b1);
    chk(soft_start_active, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0008);
    @(posedge clk);
    adc_set.vin_rms <= 12'hA00;
    cyc(20);
    consume(NEV'(1) << EV_IN_UV);
    chk(event_flags[EV_IN_OV], 1'b0);
    wr(ADDR_CTRL, 32'h0000_0009);
    cyc(20);
    chk(event_flags[EV_IN_OV], 1'b1);
    @(posedge clk);
    adc_set.vin_rms <= 12'h400;
    cyc(8);
    consume('1);
    wr(ADDR_SS_LIMIT, 32'h0000_0014);
    wr(ADDR_CTRL, 32'h0000_000A);
    cyc(40);
    chk(event_flags[EV_SS_FAIL], 1'b1);
    wr(ADDR_CTRL, 32'h0000_0008);
    @(posedge clk);
    cs_open <= 1'b1;
    cyc(40);
    chk(event_flags[EV_OC2], 1'b1);
    @(posedge clk);
    cs_open <= 1'b0;
    wr(ADDR_CCM_BLANK, 32'h0000_0003);
    cyc(100);
    chk(event_flags[EV_CCM], 1'b0);
    @(posedge clk);
    no_osc <= 1'b1;
    cyc(100);
    chk(event_flags[EV_CCM], 1'b1);
    wr(ADDR_VOUT_OV, 32'h0000_0600);
    wr(ADDR_RCS_INV, 32'h0000_0080);
    wr(ADDR_PDC, 32'h0000_0008);
    wr(ADDR_CS_OFFSET, 32'h0000_0004);
    wr(ADDR_IOUT_GAIN, 32'h0000_0100);
    wr(ADDR_VOUT_GAIN, 32'h0000_0200);
    wr(ADDR_VOUT_OFFSET, 32'h0000_0010);
    wr(ADDR_BUSFB_GAIN, 32'h0000_0200);
    @(posedge clk);
    adc_set.cs_flyback <= 12'h200;
    adc_set.zero_crossing_input <= 12'h300;
    adc_set.zcd_clamp <= 12'h300;
    cyc(40);
    rd_chk(ADDR_IPK, ipk_exp(12'h200, 16'h0080, 8, 4));
    rd_chk(ADDR_IOUT, ipk_exp(12'h200, 16'h0080, 8, 4) * 6 / 15);
    rd_chk(ADDR_VOUT, 32'h0000_0610);
    rd_chk(ADDR_BUSFB, 32'h0000_0600);
    chk(event_flags[EV_VOUT_OV], 1'b1);
    consume(NEV'(1) << EV_PLAUS);
    chk(event_flags[EV_PLAUS], 1'b0);
    wr(ADDR_BUSFB_OFFSET, 32'h0000_0100);
    cyc(40);
    chk(event_flags[EV_PLAUS], 1'b1);
    wr(ADDR_CTRL, 32'h0000_0018);
    cyc(2);
    repeat (32) begin
      @(negedge clk);
      hits += fb_valley_delay;
    end
    chk(hits, 32'd2);
    tally_and_finish();
  end
endmodule : pfp_top_tb
